// [hdl/cbx_pkg.sv]
// Shared constants, opcodes and state types for the instruction execute block
package cbx_pkg;
  // ==========================================================
  // Widths
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  // ==========================================================
  // Opcode fields
  localparam logic [3:0] OP_SKIP_SET = 4'ha;
  localparam logic [3:0] OP_TOGGLE = 4'h7;
  localparam logic [7:0] OP_BR_ZERO = 8'he0;
  localparam logic [7:0] OP_BR_OVF = 8'he4;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [3:0] OP_SECOND = 4'hf;
  localparam logic [6:0] OP_CLEAR = 7'h35;
  localparam logic [15:0] OP_WDT_CLEAR = 16'h0004;
  // Other first words that take two program words
  localparam logic [3:0] OP_LONG_MOVE = 4'hc;
  localparam logic [6:0] OP_LONG_JUMP = 7'h77;
  // ==========================================================
  // Bank, program counter steps, clear and reset values
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] RET_STEP = 21'h000004;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic [15:0] IR_RESET = 16'h0000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {CBX_Q1, CBX_Q2, CBX_Q3, CBX_Q4} cbx_phase_t;
  typedef enum logic [1:0] {CBX_EXEC, CBX_NOP, CBX_SKIP} cbx_state_t;
  typedef struct packed {
    cbx_state_t st;
    logic [15:0] ir;
    logic nop_pend;
    logic skip_pend;
    logic two_word;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic pc_load;
    logic [PC_W-1:0] pc_val;
    logic push;
    logic [PC_W-1:0] push_data;
    logic shadow_wr;
    logic [7:0] ws;
    logic [7:0] fs;
    logic [3:0] bs;
    logic z_set;
    logic wdt_clr;
    logic wdt_flags;
    logic discard;
  } cbx_exec_t;
endpackage : cbx_pkg

// [hdl/cbx_phase.sv]
// Four-phase sequencer of the instruction cycle
`timescale 1ns/1ns
module cbx_phase (
  input wire logic mclk,
  input wire logic reset_n,
  output cbx_pkg::cbx_phase_t phase
);
  import cbx_pkg::*;

  cbx_phase_t phase_q;
  cbx_phase_t phase_d;

  always_comb begin
    case (phase_q)
      CBX_Q1: phase_d = CBX_Q2;
      CBX_Q2: phase_d = CBX_Q3;
      CBX_Q3: phase_d = CBX_Q4;
      CBX_Q4: phase_d = CBX_Q1;
      default: phase_d = CBX_Q1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase_q <= CBX_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
endmodule : cbx_phase

// [hdl/cbx_exec.sv]
// Execute logic for bit test, toggle, branches, call, clear and watchdog clear
// How it works
// RULE_01: Taken skip over two-word instruction: two nops
// RULE_02: Skip-if-set discards next when bit one
// RULE_03: Toggle inverts selected bit, flags untouched
// RULE_04: Access bit zero picks access bank
// RULE_05: Overflow branch taken only when overflow set
// RULE_06: Zero branch taken only when zero set
// RULE_07: Target is instruction address plus 2+2n
// RULE_08: Taken branch adds one full nop cycle
// RULE_09: Call pushes its address plus four
// RULE_10: Fast call copies working, flags, bank
// RULE_11: Call literal loads program counter bits 20:1
// RULE_12: Call is two words, two cycles
// RULE_13: Clear writes zero and sets zero flag
// RULE_14: Watchdog clear resets counter and postscaler
// RULE_15: Watchdog clear sets both status bits
// RULE_16: Four phases; read in two, write in four
`timescale 1ns/1ns
module cbx_exec (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] instr_word,
  input wire logic [cbx_pkg::PC_W-1:0] cur_pc,
  input wire logic overflow_flag,
  input wire logic zero_flag,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_register,
  input wire logic [3:0] bank_select,
  input wire logic [7:0] mem_rdata,
  output logic [cbx_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic pc_load,
  output logic [cbx_pkg::PC_W-1:0] pc_value,
  output logic stack_push,
  output logic [cbx_pkg::PC_W-1:0] stack_top,
  output logic shadow_wr,
  output logic [7:0] working_shadow,
  output logic [7:0] flags_shadow,
  output logic [3:0] bank_select_shadow,
  output logic zero_set,
  output logic watchdog_clear,
  output logic watchdog_flags_set,
  output logic discard
);
  import cbx_pkg::*;

  cbx_phase_t phase;
  cbx_exec_t s_q;
  cbx_exec_t s_d;

  logic [15:0] iw;
  logic is_skip;
  logic is_toggle;
  logic is_clear;
  logic is_bz;
  logic is_bov;
  logic is_call;
  logic is_wdt;
  logic [7:0] bit_mask;
  logic [PC_W-1:0] br_offset;
  logic next_two_word;

  cbx_phase u_phase (
    .mclk(mclk),
    .reset_n(reset_n),
    .phase(phase)
  );

  // ==========================================================
  // Decode
  // The word is live on the input in Q1 and held in the register afterwards
  always_comb begin
    iw = (phase == CBX_Q1) ? instr_word : s_q.ir;
    is_skip = (iw[15:12] == OP_SKIP_SET);
    is_toggle = (iw[15:12] == OP_TOGGLE);
    is_clear = (iw[15:9] == OP_CLEAR);
    is_bz = (iw[15:8] == OP_BR_ZERO);
    is_bov = (iw[15:8] == OP_BR_OVF);
    is_call = (iw[15:9] == OP_CALL);
    is_wdt = (iw == OP_WDT_CLEAR);
    bit_mask = 8'h01 << iw[11:9];
    br_offset = {{(PC_W-9){iw[7]}}, iw[7:0], 1'b0};
    next_two_word = (instr_word[15:12] == OP_LONG_MOVE) ||
                    (instr_word[15:9] == OP_CALL) || (instr_word[15:9] == OP_LONG_JUMP);
  end

  // ==========================================================
  // Sequencer; every action is registered so it shows one phase later
  always_comb begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.wr = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.push = 1'b0;
    s_d.shadow_wr = 1'b0;
    s_d.z_set = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.wdt_flags = 1'b0;
    case (s_q.st)
      CBX_EXEC: begin
        case (phase) // RULE_16
          CBX_Q1: begin
            s_d.ir = instr_word;
            s_d.nop_pend = 1'b0;
            s_d.skip_pend = 1'b0;
            if (is_skip || is_toggle || is_clear) begin
              s_d.rd = 1'b1;
              // Access bank splits at 80h between bank 0 and bank 15
              if (!iw[8]) begin
                s_d.addr = {(iw[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), iw[7:0]}; // RULE_04
              end else begin
                s_d.addr = {bank_select, iw[7:0]}; // RULE_04
              end
            end
          end
          CBX_Q2: begin
            if (is_wdt) begin
              s_d.wdt_clr = 1'b1; // RULE_14
              s_d.wdt_flags = 1'b1; // RULE_15
            end
            if (is_call) begin
              s_d.push = 1'b1;
              s_d.push_data = cur_pc + RET_STEP; // RULE_09
              if (iw[8]) begin
                s_d.shadow_wr = 1'b1; // RULE_10
                s_d.ws = working_register;
                s_d.fs = status_register;
                s_d.bs = bank_select;
              end
            end
          end
          CBX_Q3: begin
            if (is_skip && ((mem_rdata & bit_mask) != 8'h00)) begin
              s_d.skip_pend = 1'b1; // RULE_02
            end
            if (is_toggle) begin
              s_d.wr = 1'b1;
              s_d.wdata = mem_rdata ^ bit_mask; // RULE_03
            end
            if (is_clear) begin
              s_d.wr = 1'b1;
              s_d.wdata = CLEAR_VALUE; // RULE_13
              s_d.z_set = 1'b1; // RULE_13
            end
            if ((is_bz && zero_flag) || (is_bov && overflow_flag)) begin // RULE_05 RULE_06
              s_d.pc_load = 1'b1;
              s_d.pc_val = cur_pc + PC_STEP + br_offset; // RULE_07
              s_d.nop_pend = 1'b1; // RULE_08
            end
            // Second call word must be on the instruction input by Q3
            if (is_call && instr_word[15:12] == OP_SECOND) begin
              s_d.pc_load = 1'b1;
              s_d.pc_val = {instr_word[11:0], iw[7:0], 1'b0}; // RULE_11
              s_d.nop_pend = 1'b1; // RULE_12
            end
          end
          CBX_Q4: begin
            if (s_q.skip_pend) begin
              s_d.st = CBX_SKIP;
              s_d.discard = 1'b1;
            end else if (s_q.nop_pend) begin
              s_d.st = CBX_NOP;
              s_d.discard = 1'b1;
            end
          end
          default: s_d.st = CBX_EXEC;
        endcase
      end
      CBX_SKIP: begin
        // The discarded word decides whether a second nop cycle follows
        if (phase == CBX_Q1) begin
          s_d.two_word = next_two_word;
        end
        if (phase == CBX_Q4) begin
          s_d.st = s_q.two_word ? CBX_NOP : CBX_EXEC; // RULE_01
          s_d.discard = s_q.two_word;
        end
      end
      CBX_NOP: begin
        if (phase == CBX_Q4) begin
          s_d.st = CBX_EXEC;
          s_d.discard = 1'b0;
        end
      end
      default: s_d.st = CBX_EXEC;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.st <= CBX_EXEC;
      s_q.ir <= IR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_addr = s_q.addr;
  assign mem_rd = s_q.rd;
  assign mem_wr = s_q.wr;
  assign mem_wdata = s_q.wdata;
  assign pc_load = s_q.pc_load;
  assign pc_value = s_q.pc_val;
  assign stack_push = s_q.push;
  assign stack_top = s_q.push_data;
  assign shadow_wr = s_q.shadow_wr;
  assign working_shadow = s_q.ws;
  assign flags_shadow = s_q.fs;
  assign bank_select_shadow = s_q.bs;
  assign zero_set = s_q.z_set;
  assign watchdog_clear = s_q.wdt_clr;
  assign watchdog_flags_set = s_q.wdt_flags;
  assign discard = s_q.discard;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_two_word_skip;
    (s_q.st == CBX_SKIP && phase == CBX_Q4 && s_q.two_word) |=> (s_q.st == CBX_NOP) [*4];
  endproperty
  a_two_word_skip: assert property (p_two_word_skip) else $error("no second nop"); // RULE_01

  property p_skip_set;
    (s_q.st == CBX_EXEC && phase == CBX_Q3 && is_skip && (mem_rdata & bit_mask) != 8'h00)
      |-> ##2 (s_q.st == CBX_SKIP && discard);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip not taken"); // RULE_02

  property p_toggle;
    (mem_wr && s_q.ir[15:12] == OP_TOGGLE)
      |-> mem_wdata == ($past(mem_rdata) ^ (8'h01 << s_q.ir[11:9])) && !zero_set;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle data wrong"); // RULE_03

  property p_bank;
    (mem_rd && s_q.ir[8]) |-> mem_addr[11:8] == $past(bank_select);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select ignored"); // RULE_04

  property p_bov;
    (pc_load && s_q.ir[15:8] == OP_BR_OVF) |-> $past(overflow_flag);
  endproperty
  a_bov: assert property (p_bov) else $error("overflow branch wrong"); // RULE_05

  property p_bz;
    (pc_load && s_q.ir[15:8] == OP_BR_ZERO) |-> $past(zero_flag) && !zero_set;
  endproperty
  a_bz: assert property (p_bz) else $error("zero branch wrong"); // RULE_06

  property p_target;
    (pc_load && (s_q.ir[15:8] == OP_BR_ZERO || s_q.ir[15:8] == OP_BR_OVF))
      |-> pc_value == $past(cur_pc) + PC_STEP + {{(PC_W-9){s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong"); // RULE_07

  property p_nop_cycle;
    $rose(pc_load) |-> ##1 (discard && s_q.st == CBX_NOP) [*4] ##1 !discard;
  endproperty
  a_nop_cycle: assert property (p_nop_cycle) else $error("nop cycle missing"); // RULE_08 RULE_12

  property p_push;
    stack_push |-> stack_top == $past(cur_pc) + RET_STEP ##1 (phase == CBX_Q4);
  endproperty
  a_push: assert property (p_push) else $error("return address wrong"); // RULE_09

  property p_shadow;
    shadow_wr |-> stack_push && s_q.ir[8] && working_shadow == $past(working_register);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow copy wrong"); // RULE_10

  property p_call_pc;
    (pc_load && s_q.ir[15:9] == OP_CALL)
      |-> pc_value == {$past(instr_word[11:0]), s_q.ir[7:0], 1'b0};
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target wrong"); // RULE_11

  property p_clear;
    zero_set |-> mem_wr && mem_wdata == CLEAR_VALUE;
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong"); // RULE_13

  property p_wdt;
    watchdog_clear |-> watchdog_flags_set ##1 !watchdog_clear;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong"); // RULE_14 RULE_15
endmodule : cbx_exec

// [verification/cbx_exec_tb.sv]
// Self-checking testbench for the bit, branch and call execute block
`timescale 1ns/1ns
module testbench;
  import cbx_pkg::*;
  // ==========================================================
  // Ports and bench state
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [PC_W-1:0] cur_pc = 21'h000000;
  logic overflow_flag = 1'b0;
  logic zero_flag = 1'b0;
  logic [7:0] working_register = 8'h3c;
  logic [7:0] status_register = 8'hc5;
  logic [3:0] bank_select = 4'h0;
  logic [7:0] mem_rdata = 8'h00;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_rd, mem_wr, pc_load, stack_push, shadow_wr, zero_set;
  logic watchdog_clear, watchdog_flags_set, discard;
  logic [7:0] mem_wdata, working_shadow, flags_shadow;
  logic [3:0] bank_select_shadow;
  logic [PC_W-1:0] pc_value, stack_top;
  // Context for the next instruction, driven together with its word
  logic [PC_W-1:0] pc_g = 21'h001000;
  logic ov_g = 1'b0;
  logic z_g = 1'b0;
  logic [3:0] bs_g = 4'h3;
  // Pulse counts and last sample index: rd wr pc push shadow z wdt flags discard
  int cnt [9];
  int at [9];
  int ec = 0;
  int failures = 0;
  int num_checks = 0;

  cbx_exec dut_u (
    .mclk(mclk), .reset_n(reset_n), .instr_word(instr_word), .cur_pc(cur_pc),
    .overflow_flag(overflow_flag), .zero_flag(zero_flag),
    .working_register(working_register), .status_register(status_register),
    .bank_select(bank_select), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc_load(pc_load),
    .pc_value(pc_value), .stack_push(stack_push), .stack_top(stack_top),
    .shadow_wr(shadow_wr), .working_shadow(working_shadow), .flags_shadow(flags_shadow),
    .bank_select_shadow(bank_select_shadow), .zero_set(zero_set),
    .watchdog_clear(watchdog_clear), .watchdog_flags_set(watchdog_flags_set),
    .discard(discard)
  );

  always #25 mclk = ~mclk;

  // ==========================================================
  // Common tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic clr();
    cnt = '{default: 0};
    at = '{default: 0};
  endtask : clr

  // One instruction cycle; entered on the falling edge inside Q1 with its word on the bus.
  // The next word and its context go out on the Q4 edge so Q1 sees them settled.
  task automatic cyc(input logic [15:0] w2, input logic [7:0] rd, input logic [15:0] nx);
    logic [8:0] sv;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      if (i == 0) begin
        instr_word <= w2;
        mem_rdata <= rd;
      end
      if (i == 3) begin
        instr_word <= nx;
        cur_pc <= pc_g;
        overflow_flag <= ov_g;
        zero_flag <= z_g;
        bank_select <= bs_g;
      end
      @(negedge mclk);
      ec++;
      sv = {discard, watchdog_flags_set, watchdog_clear, zero_set, shadow_wr,
            stack_push, pc_load, mem_wr, mem_rd};
      for (int j = 0; j < 9; j++) begin
        cnt[j] += (sv[j] === 1'b1);
        if (sv[j] === 1'b1) at[j] = ec;
      end
    end
  endtask : cyc

  task automatic go(input logic [15:0] w, input logic [15:0] w2, input logic [7:0] rd);
    cyc(16'h0000, 8'h00, w);
    clr();
    cyc(w2, rd, 16'h0000);
    cyc(16'h0000, 8'h00, 16'h0000);
  endtask : go

  // ==========================================================
  // Scenarios
  task automatic rmw(input logic [15:0] w, input logic [7:0] rd, input logic [7:0] ew,
      input int ez);
    go(w, w, rd);
    chk(cnt[0], 1);
    chk(cnt[1], 1);
    chk(at[1] - at[0], 2);
    chk(mem_addr, w[8] ? {bs_g, w[7:0]} : {(w[7] ? 4'hf : 4'h0), w[7:0]});
    chk(mem_wdata, ew);
    chk(cnt[5], ez);
  endtask : rmw

  task automatic br(input logic [7:0] op, input logic ov, input logic z, input logic [7:0] n);
    logic tk;
    logic [PC_W-1:0] tgt;
    tk = (op == 8'he0) ? z : ov;
    // Held at counter width so a backward target wraps as the hardware does
    tgt = pc_g + 21'd2 + {{12{n[7]}}, n, 1'b0};
    ov_g = ov;
    z_g = z;
    go({op, n}, {op, n}, 8'h00);
    chk(cnt[2], tk);
    if (tk) chk(pc_value, tgt);
    chk(cnt[8], tk ? 4 : 0);
    chk(cnt[5], 0);
  endtask : br

  task automatic call(input logic s, input logic [19:0] k);
    go({7'h76, s, k[7:0]}, {4'hf, k[19:8]}, 8'h00);
    chk(cnt[3], 1);
    chk(stack_top, pc_g + 21'd4);
    chk(at[2] > at[3], 1);
    chk(cnt[2], 1);
    chk(pc_value, {k, 1'b0});
    chk(cnt[4], s);
    if (s) begin
      chk({working_shadow, flags_shadow}, {8'h3c, 8'hc5});
      chk(bank_select_shadow, bs_g);
    end
    chk(cnt[8], 4);
  endtask : call

  task automatic t_wdt();
    go(16'h0004, 16'h0004, 8'h00);
    chk(cnt[6], 1);
    chk(cnt[7], 1);
    chk(cnt[1] + cnt[2], 0);
  endtask : t_wdt

  // Skip-if-set on bit 1 of file 10h, followed by a toggle or by a two-word instruction
  task automatic skip(input logic [7:0] rd, input logic two, input logic [15:0] lw);
    logic [15:0] sk, tg;
    sk = {4'ha, 3'd1, 1'b0, 8'h10};
    tg = {4'h7, 3'd2, 1'b0, 8'h11};
    cyc(16'h0000, 8'h00, sk);
    clr();
    if (two) begin
      cyc(sk, rd, lw);
      cyc(16'hf034, 8'h00, 16'hf034);
      cyc(16'hf034, 8'h00, tg);
    end else begin
      cyc(sk, rd, tg);
    end
    cyc(tg, 8'h00, 16'h0000);
    cyc(16'h0000, 8'h00, 16'h0000);
    chk(cnt[8], rd[1] ? (two ? 8 : 4) : 0);
    chk(cnt[1], (rd[1] && !two) ? 0 : 1);
    chk(cnt[2] + cnt[3], 0);
  endtask : skip

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    rmw({4'h7, 3'd4, 1'b0, 8'h25}, 8'h75, 8'h65, 0);
    rmw({4'h7, 3'd7, 1'b1, 8'ha0}, 8'h0f, 8'h8f, 0);
    rmw({4'h7, 3'd0, 1'b0, 8'h90}, 8'h00, 8'h01, 0);
    rmw({7'h35, 1'b1, 8'h5a}, 8'h5a, 8'h00, 1);
    rmw({7'h35, 1'b0, 8'h80}, 8'hff, 8'h00, 1);
    for (int k = 0; k < 8; k++) begin
      br(k[2] ? 8'he4 : 8'he0, k[0], k[1], k[0] ? 8'h80 : 8'h7f);
    end
    call(1'b0, 20'habcde);
    bs_g = 4'h9;
    call(1'b1, 20'hfffff);
    t_wdt();
    skip(8'h02, 1'b0, 16'h0000);
    skip(8'hfd, 1'b0, 16'h0000);
    skip(8'h02, 1'b1, 16'hec12);
    skip(8'h06, 1'b1, 16'hc123);
    skip(8'h02, 1'b1, 16'hee05);
    stop_test();
  end

  // A hung run would otherwise never reach the verdict
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : testbench
